// ===== core/psr_pkg.sv
// package for the socket power serial and reset block
// assumes a 32-bit apb master and one external power switch
package psr_pkg;

  // ***************************************************
  // register map
  // ***************************************************
  localparam int PSR_AW = 8;
  localparam logic [7:0] PSR_SYS_CTRL_OFF = 8'h80;
  localparam logic [7:0] PSR_PWR_WORD_OFF = 8'h84;
  localparam logic [7:0] PSR_STATUS_OFF = 8'h88;

  // ***************************************************
  // fields and reset values
  // ***************************************************
  localparam int PSR_CLKOUT_BIT = 27;
  localparam int PSR_PME_LSB = 0;
  localparam int PSR_PME_W = 8;
  localparam int PSR_ST_BUSY_BIT = 0;
  localparam int PSR_ST_HOLD_BIT = 1;
  localparam int PSR_ST_SUSP_BIT = 2;
  localparam logic [31:0] PSR_SYS_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] PSR_PWR_WORD_RST = 32'h0000_0000;

  // ***************************************************
  // types
  // ***************************************************
  typedef enum logic [1:0] {
    PSR_IDLE,
    PSR_SHIFT,
    PSR_LATCH,
    PSR_HOLD
  } psr_link_st_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [PSR_AW-1:0] paddr;
    logic [31:0] pwdata;
  } psr_apb_req_t;

  typedef struct packed {
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } psr_apb_rsp_t;

  // oe_n low means the pin is driven
  typedef struct packed {
    logic clk;
    logic clk_oe_n;
    logic data;
    logic data_oe_n;
    logic latch;
    logic latch_oe_n;
  } psr_pins_t;

endpackage : psr_pkg

// ===== core/psr_switch_serial.sv
// power switch serial port with global/bus reset and suspend handling
// assumes apb on clk_i and a free-running link clock link_clk_i
//
// Summary of operation
// - switch samples data on rising switch clock; data held stable there
// - switch clock pin is input after reset; bit 27 at 80h drives it
// - power settings go out serially, one bit per clock, msb first
// - latch output tells the switch the shifted word is valid
// - global reset without suspend: outputs float, all registers default
// - bus reset: outputs float, some registers clear, no function
// - bus reset keeps power-management-event context
// - suspend: global reset floats outputs but clears nothing
// - suspend: bus reset floats outputs, register contents kept
// - all bus transfers timed and sampled on rising bus clock
//
// Added by the designer: register access over APB.
`timescale 1ns/100ps
`default_nettype none

module psr_switch_serial
  import psr_pkg::*;
#(
  parameter int WORD_W = 16
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire psr_apb_req_t apb_i,
  output psr_apb_rsp_t apb_o,
  input wire logic global_reset_n_i,
  input wire logic bus_reset_n_i,
  input wire logic suspend_i,
  input wire logic link_clk_i,
  input wire logic switch_clock_i,
  output psr_pins_t pins_o
);

  localparam int CNT_W = (WORD_W > 2) ? $clog2(WORD_W) : 1;

  if (WORD_W < 2 || WORD_W > 32) begin : g_chk
    $error("psr_switch_serial: WORD_W must be 2..32");
  end

  // ***************************************************
  // state
  // ***************************************************
  typedef struct packed {
    logic [1:0] gr_s;
    logic [1:0] br_s;
    logic [1:0] su_s;
    logic [1:0] dn_s;
    logic hold;
    logic clk_out_en;
    logic [PSR_PME_W-1:0] pme;
    logic [WORD_W-1:0] word;
    logic req_tgl;
    logic [31:0] prdata;
    logic pslverr;
  } psr_bus_t;

  typedef struct packed {
    logic [1:0] rq_s;
    logic [1:0] hz_s;
    logic [1:0] ce_s;
    logic [1:0] ck_s;
    logic rq_last;
    logic ck_last;
    psr_link_st_t st;
    logic [WORD_W-1:0] shreg;
    logic [CNT_W-1:0] cnt;
    logic sclk;
    logic ph;
    logic data;
    logic latch;
    logic done_tgl;
    logic c_oe_n;
    logic d_oe_n;
  } psr_link_t;

  psr_bus_t br;
  psr_bus_t bn;
  psr_link_t lr;
  psr_link_t ln;

  logic gr_act;
  logic bs_act;
  logic sus;
  logic busy;
  logic setup;
  logic access;
  logic drive;
  logic rise;
  logic fall;

  assign gr_act = ~br.gr_s[1];
  assign bs_act = ~br.br_s[1];
  assign sus = br.su_s[1];
  assign busy = br.req_tgl ^ br.dn_s[1];
  assign setup = apb_i.psel & ~apb_i.penable;
  assign access = apb_i.psel & apb_i.penable;

  // ***************************************************
  // bus domain
  // ***************************************************
  // zero wait states: read data is staged in the setup cycle
  always_comb begin
    logic [31:0] rd_sys;
    logic [31:0] rd_st;
    rd_sys = '0;
    rd_st = '0;
    bn = br;
    // reset pins and suspend pass two flops first
    bn.gr_s = {br.gr_s[0], global_reset_n_i};
    bn.br_s = {br.br_s[0], bus_reset_n_i};
    bn.su_s = {br.su_s[0], suspend_i};
    bn.dn_s = {br.dn_s[0], lr.done_tgl};
    bn.hold = gr_act | bs_act;
    rd_sys[PSR_CLKOUT_BIT] = br.clk_out_en;
    rd_sys[PSR_PME_LSB +: PSR_PME_W] = br.pme;
    rd_st[PSR_ST_BUSY_BIT] = busy;
    rd_st[PSR_ST_HOLD_BIT] = br.hold;
    rd_st[PSR_ST_SUSP_BIT] = sus;
    if (setup) begin
      bn.prdata = '0;
      bn.pslverr = 1'b0;
      if (br.hold) begin
        bn.pslverr = 1'b1;
      end else begin
        case (apb_i.paddr)
          PSR_SYS_CTRL_OFF: begin
            bn.prdata = rd_sys;
          end
          PSR_PWR_WORD_OFF: begin
            bn.prdata = 32'(br.word);
            bn.pslverr = apb_i.pwrite & busy;
          end
          PSR_STATUS_OFF: begin
            bn.prdata = rd_st;
            bn.pslverr = apb_i.pwrite;
          end
          default: begin
            bn.pslverr = 1'b1;
          end
        endcase
      end
    end
    if (access && apb_i.pwrite && !br.pslverr && !br.hold) begin
      case (apb_i.paddr)
        PSR_SYS_CTRL_OFF: begin
          bn.clk_out_en = apb_i.pwdata[PSR_CLKOUT_BIT];
          bn.pme = apb_i.pwdata[PSR_PME_LSB +: PSR_PME_W];
        end
        PSR_PWR_WORD_OFF: begin
          bn.word = apb_i.pwdata[WORD_W-1:0];
          bn.req_tgl = ~br.req_tgl;
        end
        default: begin
          bn.req_tgl = br.req_tgl;
        end
      endcase
    end
    if (gr_act && !sus) begin
      bn.clk_out_en = PSR_SYS_CTRL_RST[PSR_CLKOUT_BIT];
      bn.pme = PSR_SYS_CTRL_RST[PSR_PME_LSB +: PSR_PME_W];
      bn.word = PSR_PWR_WORD_RST[WORD_W-1:0];
      bn.prdata = '0;
      bn.pslverr = 1'b0;
    end else if (bs_act && !sus) begin
      bn.clk_out_en = PSR_SYS_CTRL_RST[PSR_CLKOUT_BIT];
      bn.word = PSR_PWR_WORD_RST[WORD_W-1:0];
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      br <= '0;
      br.hold <= 1'b1;
      br.clk_out_en <= PSR_SYS_CTRL_RST[PSR_CLKOUT_BIT];
      br.pme <= PSR_SYS_CTRL_RST[PSR_PME_LSB +: PSR_PME_W];
      br.word <= PSR_PWR_WORD_RST[WORD_W-1:0];
    end else begin
      br <= bn;
    end
  end

  assign apb_o = '{
    pready: access,
    prdata: br.prdata,
    pslverr: br.pslverr
  };

  // ***************************************************
  // link domain
  // ***************************************************
  // in input mode the pin clock is oversampled, so it must run
  // well below a third of the link clock rate
  always_comb begin
    ln = lr;
    ln.rq_s = {lr.rq_s[0], br.req_tgl};
    ln.hz_s = {lr.hz_s[0], br.hold};
    ln.ce_s = {lr.ce_s[0], br.clk_out_en};
    ln.ck_s = {lr.ck_s[0], switch_clock_i};
    ln.ck_last = lr.ck_s[1];
    drive = lr.ce_s[1];
    ln.ph = drive && lr.st != PSR_IDLE && !lr.ph;
    rise = drive ? (lr.st != PSR_IDLE && !lr.ph)
                 : (lr.ck_s[1] && !lr.ck_last);
    fall = drive ? (lr.st != PSR_IDLE && lr.ph)
                 : (!lr.ck_s[1] && lr.ck_last);
    // no clock edge after last bit
    ln.sclk = drive && lr.st == PSR_SHIFT && !lr.ph;
    ln.c_oe_n = lr.hz_s[1] | ~drive;
    ln.d_oe_n = lr.hz_s[1];
    case (lr.st)
      PSR_IDLE: begin
        if (lr.rq_s[1] != lr.rq_last) begin
          ln.rq_last = lr.rq_s[1];
          ln.shreg = br.word;
          ln.data = br.word[WORD_W-1];
          ln.cnt = '0;
          ln.st = PSR_SHIFT;
        end
      end
      PSR_SHIFT: begin
        // data moves on falling edge only
        if (fall) begin
          ln.shreg = {lr.shreg[WORD_W-2:0], 1'b0};
          ln.data = lr.shreg[WORD_W-2];
        end
        if (rise) begin
          if (lr.cnt == CNT_W'(WORD_W - 1)) begin
            ln.st = PSR_LATCH;
          end else begin
            ln.cnt = lr.cnt + 1'b1;
          end
        end
      end
      PSR_LATCH: begin
        if (fall) begin
          ln.latch = 1'b1;
          ln.st = PSR_HOLD;
        end
      end
      PSR_HOLD: begin
        if (fall) begin
          ln.latch = 1'b0;
          ln.done_tgl = lr.rq_last;
          ln.st = PSR_IDLE;
        end
      end
      default: begin
        ln.st = PSR_IDLE;
      end
    endcase
    if (lr.hz_s[1]) begin
      ln.st = PSR_IDLE;
      ln.sclk = 1'b0;
      ln.ph = 1'b0;
      ln.latch = 1'b0;
      ln.data = 1'b0;
      ln.rq_last = lr.rq_s[1];
      ln.done_tgl = lr.rq_s[1];
    end
  end

  // reset release is not synchronised to the link clock; the
  // pins stay floating for two link edges anyway
  always_ff @(posedge link_clk_i or posedge reset_i) begin
    if (reset_i) begin
      lr <= '0;
      lr.hz_s <= 2'b11;
      lr.st <= PSR_IDLE;
      lr.c_oe_n <= 1'b1;
      lr.d_oe_n <= 1'b1;
    end else begin
      lr <= ln;
    end
  end

  assign pins_o = '{
    clk: lr.sclk,
    clk_oe_n: lr.c_oe_n,
    data: lr.data,
    data_oe_n: lr.d_oe_n,
    latch: lr.latch,
    latch_oe_n: lr.d_oe_n
  };

  // ***************************************************
  // checks
  // ***************************************************
  chk_clk_pin_input: assert property (
    @(posedge link_clk_i) disable iff (reset_i)
    !lr.ce_s[1] |=> lr.c_oe_n
  ) else $error("switch clock driven while not selected");

  chk_data_stable: assert property (
    @(posedge link_clk_i) disable iff (reset_i)
    (lr.ce_s[1] && $rose(lr.sclk)) |-> $stable(lr.data)
  ) else $error("data changed at switch clock rise");

  chk_shift_order: assert property (
    @(posedge link_clk_i) disable iff (reset_i)
    (lr.st == PSR_SHIFT && fall && !lr.hz_s[1])
      |=> lr.data == $past(lr.shreg[WORD_W-2])
  ) else $error("wrong bit shifted out");

  chk_latch_pulse: assert property (
    @(posedge link_clk_i) disable iff (reset_i)
    (lr.ce_s[1] && $rose(lr.latch) && !lr.hz_s[1])
      |-> lr.latch ##1 (lr.latch || lr.hz_s[1]) ##1 !lr.latch
  ) else $error("latch pulse not two link cycles");

  chk_latch_after_shift: assert property (
    @(posedge link_clk_i) disable iff (reset_i)
    $rose(lr.latch) |-> $past(lr.st) == PSR_LATCH
      && $past(lr.cnt) == CNT_W'(WORD_W - 1)
  ) else $error("latch raised before last bit");

  chk_hold_floats: assert property (
    @(posedge link_clk_i) disable iff (reset_i)
    lr.hz_s[1] |=> lr.d_oe_n && lr.c_oe_n && !lr.latch
      && lr.st == PSR_IDLE
  ) else $error("pins driven during reset");

  chk_global_clear: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (gr_act && !sus) |=> br.word == PSR_PWR_WORD_RST[WORD_W-1:0]
      && br.pme == PSR_SYS_CTRL_RST[PSR_PME_LSB +: PSR_PME_W]
      && br.clk_out_en == PSR_SYS_CTRL_RST[PSR_CLKOUT_BIT]
  ) else $error("global reset left a register set");

  chk_bus_keep_pme: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (bs_act && !gr_act && !sus && br.hold) |=> $stable(br.pme)
      && br.word == PSR_PWR_WORD_RST[WORD_W-1:0]
  ) else $error("bus reset disturbed pme context");

  chk_suspend_keep: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (sus && br.hold && (gr_act || bs_act)) |=> $stable(br.word)
      && $stable(br.pme) && $stable(br.clk_out_en)
  ) else $error("register cleared under suspend");

  chk_apb_write: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (access && apb_i.pwrite && apb_i.paddr == PSR_SYS_CTRL_OFF
      && !br.pslverr && !br.hold && br.gr_s[1] && br.br_s[1]
      && !gr_act && !bs_act)
      |=> br.clk_out_en == $past(apb_i.pwdata[PSR_CLKOUT_BIT])
  ) else $error("control write not taken");

endmodule : psr_switch_serial

`default_nettype wire

// ===== sim/psr_switch_model.sv
// power switch model: shifts serial data in and applies it on latch
// assumes the switch clock pin level resolved by the bench
`timescale 1ns/100ps
`default_nettype none

module psr_switch_model #(
  parameter int WORD_W = 16
) (
  input wire logic clk_pin_i,
  input wire logic data_i,
  input wire logic data_oe_n_i,
  input wire logic latch_i,
  input wire logic latch_oe_n_i,
  output logic [31:0] word_o,
  output logic [31:0] latch_cnt_o,
  output logic bad_o
);
  // ***************************************************
  // shift and latch
  // ***************************************************
  logic [31:0] sh = '0;
  logic [31:0] cnt = '0;
  logic [31:0] base = '0;

  initial begin
    word_o = '0;
    latch_cnt_o = '0;
    bad_o = 1'b0;
  end

  // sample on rise
  // a floating data line is never taken as a bit
  always @(posedge clk_pin_i) begin
    if (!data_oe_n_i) begin
      sh <= {sh[30:0], data_i};
      cnt <= cnt + 1;
    end
  end

  always @(posedge latch_i) begin
    if (!latch_oe_n_i) begin
      if (cnt - base != WORD_W) begin
        bad_o <= 1'b1;
      end
      base <= cnt;
      word_o <= sh & ~(32'hffff_ffff << WORD_W);
      latch_cnt_o <= latch_cnt_o + 1;
    end
  end
endmodule : psr_switch_model

`default_nettype wire

// ===== sim/tb_socket_power_serial_and_reset.sv
// testbench for the socket power serial and reset block
// assumes the power switch model; both clocks made here
`timescale 1ns/100ps
`default_nettype none

module tb_socket_power_serial_and_reset;
  import psr_pkg::*;
  localparam int WW = 16;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic link_clk = 1'b0;
  logic ext_clk = 1'b0;
  logic global_reset_n = 1'b1;
  logic bus_reset_n = 1'b1;
  logic suspend = 1'b0;
  psr_apb_req_t req = '0;
  psr_apb_rsp_t rsp;
  psr_pins_t pins;
  wire logic clk_pin;
  logic [31:0] word;
  logic [31:0] lcnt;
  logic [31:0] rd;
  logic bad;
  logic err;
  int error_cnt = 0;
  int total_checks = 0;
  int cyc = 0;

  // external clock runs only during the input-mode frame
  assign clk_pin = pins.clk_oe_n ? ext_clk : pins.clk;

  psr_switch_serial #(.WORD_W(WW)) psr_switch_serial_inst (
    .clk_i(clk_i), .reset_i(reset_i), .apb_i(req), .apb_o(rsp),
    .global_reset_n_i(global_reset_n), .bus_reset_n_i(bus_reset_n),
    .suspend_i(suspend), .link_clk_i(link_clk),
    .switch_clock_i(clk_pin), .pins_o(pins));

  psr_switch_model #(.WORD_W(WW)) psr_switch_model_inst (
    .clk_pin_i(clk_pin), .data_i(pins.data), .data_oe_n_i(pins.data_oe_n),
    .latch_i(pins.latch), .latch_oe_n_i(pins.latch_oe_n),
    .word_o(word), .latch_cnt_o(lcnt), .bad_o(bad));

  // ***************************************************
  // clocks, timeout, helpers
  // ***************************************************
  always #50 clk_i = ~clk_i;
  initial begin
    #7;
    forever #24 link_clk = ~link_clk;
  end

  always @(posedge clk_i) begin
    cyc = cyc + 1;
    if (cyc == 30000) begin
      error_cnt = error_cnt + 1;
      finish_test();
    end
  end

  task finish_test();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finish_test

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks = total_checks + 1;
    if (seen !== exp) begin
      error_cnt = error_cnt + 1;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // request held until pready is seen high at a rising edge
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk_i);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
    @(posedge clk_i);
    req.penable <= 1'b1;
    do begin
      @(posedge clk_i);
    end while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb

  task rchk(input logic [7:0] a, input logic [31:0] exp, input logic e);
    apb(1'b0, a, 32'h0);
    chk("prdata", rd, exp);
    chk("pslverr", 32'(err), 32'(e));
  endtask : rchk

  task floats();
    repeat (20) @(posedge clk_i);
    chk("oe_n", 32'({pins.clk_oe_n, pins.data_oe_n, pins.latch_oe_n}), 32'h7);
  endtask : floats

  task settle();
    repeat (10) @(posedge clk_i);
  endtask : settle

  // ***************************************************
  // scenarios
  // ***************************************************
  task t_boot();
    chk("clk_oe_n", 32'(pins.clk_oe_n), 32'h1);
    rchk(PSR_SYS_CTRL_OFF, PSR_SYS_CTRL_RST, 1'b0);
    rchk(8'h90, 32'h0, 1'b1);
    apb(1'b1, PSR_STATUS_OFF, 32'h0);
    chk("st_wr", 32'(err), 32'h1);
  endtask : t_boot

  task t_shift();
    logic [31:0] w [2];
    logic [31:0] prev;
    w = '{32'h0000_a5c3, 32'h0000_8001};
    apb(1'b1, PSR_SYS_CTRL_OFF, 32'h0800_005a);
    foreach (w[i]) begin
      prev = lcnt;
      apb(1'b1, PSR_PWR_WORD_OFF, w[i]);
      apb(1'b1, PSR_PWR_WORD_OFF, 32'h0000_ffff);
      chk("busy_wr", 32'(err), 32'h1);
      while (lcnt === prev) begin
        @(posedge clk_i);
      end
      do apb(1'b0, PSR_STATUS_OFF, 32'h0);
      while (rd[PSR_ST_BUSY_BIT] !== 1'b0);
      chk("word", word, w[i]);
      chk("latches", lcnt, prev + 1);
      chk("bad", 32'(bad), 32'h0);
      chk("clk_oe_n", 32'(pins.clk_oe_n), 32'h0);
    end
  endtask : t_shift

  // pin left as input: the bench clocks the frame, slow against link
  task t_ext_clock();
    logic [31:0] prev;
    prev = lcnt;
    apb(1'b1, PSR_SYS_CTRL_OFF, 32'h0000_005a);
    settle();
    apb(1'b1, PSR_PWR_WORD_OFF, 32'h0000_3c96);
    settle();
    // one pulse more than the word: the latch ends on the next fall
    repeat (WW + 1) begin
      repeat (4) @(posedge clk_i);
      ext_clk <= 1'b1;
      repeat (4) @(posedge clk_i);
      ext_clk <= 1'b0;
    end
    do apb(1'b0, PSR_STATUS_OFF, 32'h0);
    while (rd[PSR_ST_BUSY_BIT] !== 1'b0);
    chk("ext_word", word, 32'h0000_3c96);
    chk("ext_latches", lcnt, prev + 1);
    chk("ext_bad", 32'(bad), 32'h0);
    chk("ext_clk_oe_n", 32'(pins.clk_oe_n), 32'h1);
  endtask : t_ext_clock

  task t_bus_reset();
    bus_reset_n <= 1'b0;
    floats();
    rchk(PSR_SYS_CTRL_OFF, 32'h0, 1'b1);
    bus_reset_n <= 1'b1;
    settle();
    rchk(PSR_SYS_CTRL_OFF, 32'h0000_005a, 1'b0);
  endtask : t_bus_reset

  task t_global_reset();
    apb(1'b1, PSR_SYS_CTRL_OFF, 32'h0800_00a5);
    global_reset_n <= 1'b0;
    bus_reset_n <= 1'b0;
    floats();
    global_reset_n <= 1'b1;
    bus_reset_n <= 1'b1;
    settle();
    rchk(PSR_SYS_CTRL_OFF, PSR_SYS_CTRL_RST, 1'b0);
  endtask : t_global_reset

  task t_suspend();
    apb(1'b1, PSR_SYS_CTRL_OFF, 32'h0800_00a5);
    suspend <= 1'b1;
    settle();
    rchk(PSR_STATUS_OFF, 32'h0000_0004, 1'b0);
    global_reset_n <= 1'b0;
    floats();
    global_reset_n <= 1'b1;
    bus_reset_n <= 1'b0;
    floats();
    bus_reset_n <= 1'b1;
    settle();
    suspend <= 1'b0;
    settle();
    rchk(PSR_SYS_CTRL_OFF, 32'h0800_00a5, 1'b0);
  endtask : t_suspend

  initial begin
    repeat (12) @(posedge clk_i);
    reset_i <= 1'b0;
    settle();
    t_boot();
    t_shift();
    t_ext_clock();
    t_bus_reset();
    t_global_reset();
    t_suspend();
    finish_test();
  end
endmodule : tb_socket_power_serial_and_reset

`default_nettype wire
